// *** hw/pwr_save_pkg.sv ***
package pwr_save_pkg;

  // ----------------------------------------
  // power control register bit positions
  // ----------------------------------------
  localparam int IDLE_ARM_BIT   = 0;          // 01h
  localparam int PDOWN_ARM_BIT  = 1;          // 02h
  localparam int SLOW_BIT       = 4;          // 10h
  localparam int IDLE_GO_BIT    = 5;          // 20h
  localparam int PDOWN_GO_BIT   = 6;          // 40h
  localparam logic [7:0] PCTL_RESET = 8'h00;  // value after reset

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SLOW_DIV        = 32;                        // slow-down divide ratio
  localparam int CLK_HZ          = 20000000;                  // mclk_i rate
  localparam int WAKE_DELAY_US   = 1000;                      // oscillator settle, 1 ms
  localparam int WAKE_DELAY_CYC  = (CLK_HZ / 1000000) * WAKE_DELAY_US;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN,
    MODE_WAKE
  } pmode_t;

endpackage

// *** hw/clk_div_en.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// divide-by-n enable pulse generator
// ----------------------------------------
module clk_div_en (
  input  wire logic mclk_i,     // system clock
  input  wire logic resetn_i,   // async reset, active low
  input  wire logic run_i,      // counting allowed
  output logic      tick_o      // one-cycle enable every n clocks
);
  localparam int          N   = pwr_save_pkg::SLOW_DIV;
  localparam logic [4:0]  TOP = 5'(N - 1);

  logic [4:0] cnt_r;

  // free divider; held at zero while stopped so restart is aligned
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 5'h00;
    end else if (!run_i) begin
      cnt_r <= 5'h00;
    end else if (cnt_r == TOP) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  assign tick_o = run_i && (cnt_r == TOP);
endmodule

// *** hw/power_saving_mode_control.sv ***
`timescale 1ns/10ps
// Function
// RULE1 - idle stops cpu clock, oscillator runs
// RULE2 - idle keeps peripheral clock running
// RULE3 - idle preserves cpu state
// RULE4 - idle ends on enabled interrupt or reset
// RULE5 - idle entry: write 01h then 20h
// RULE6 - power-down stops oscillator and everything
// RULE7 - power-down preserves ram and registers
// RULE8 - power-down entry: write 02h then 40h
// RULE9 - power-down ends on reset or pin pulse
// RULE10 - pin wake waits 1 ms, then interrupt
// RULE11 - slow-down divides all clocks by 32
// RULE12 - slow-down set 10h, cleared by 0efh/reset
// RULE13 - slow-down combines with idle
// RULE14 - reset clears every power-saving bit
module power_saving_mode_control #(
  parameter int WAKE_CYC = pwr_save_pkg::WAKE_DELAY_CYC  // settle delay in clocks
) (
  input  wire logic       mclk_i,       // 20 MHz oscillator clock
  input  wire logic       resetn_i,     // async hardware reset, active low
  input  wire logic       pctl_we_i,    // power control register write strobe
  input  wire logic [7:0] pctl_wdata_i, // value written
  output logic      [7:0] pctl_rdata_o, // power control register readback
  input  wire logic       periph_irq_i, // any enabled peripheral interrupt
  input  wire logic       ext_external_interrupt_zero_pin_i,   // external_interrupt_zero_pin level
  input  wire logic       can_rx_i,     // can_receive_pin level
  output logic            osc_en_o,     // oscillator enable
  output logic            cpu_clk_en_o, // cpu clock enable pulse
  output logic            per_clk_en_o, // peripheral clock enable pulse
  output logic            hold_state_o, // ram and registers must hold
  output logic            wake_irq_o,   // power-down wake-up interrupt pulse
  output logic            idle_o,       // idle mode status
  output logic            pdown_o       // power-down status
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  pwr_save_pkg::pmode_t mode_r;
  logic [7:0]  pctl_r;
  logic [2:0]  external_interrupt_zero_pin_sync_r;
  logic [2:0]  rx_sync_r;
  logic        external_interrupt_zero_pin_lvl_r;
  logic        rx_lvl_r;
  logic [31:0] wake_cnt_r;
  logic        wake_irq_r;
  logic        div_tick;
  logic        pin_wake;

  localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYC - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      external_interrupt_zero_pin_sync_r <= 3'h7;
      rx_sync_r   <= 3'h7;
    end else begin
      external_interrupt_zero_pin_sync_r <= {external_interrupt_zero_pin_sync_r[1:0], ext_external_interrupt_zero_pin_i};
      rx_sync_r   <= {rx_sync_r[1:0], can_rx_i};
    end
  end

  // filtered levels, idle high
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      external_interrupt_zero_pin_lvl_r <= 1'b1;
      rx_lvl_r   <= 1'b1;
    end else begin
      if (external_interrupt_zero_pin_sync_r[1] == external_interrupt_zero_pin_sync_r[2]) external_interrupt_zero_pin_lvl_r <= external_interrupt_zero_pin_sync_r[2];
      if (rx_sync_r[1] == rx_sync_r[2]) rx_lvl_r <= rx_sync_r[2];
    end
  end

  // a low on either wake pin
  assign pin_wake = !external_interrupt_zero_pin_lvl_r || !rx_lvl_r; // RULE9

  // ----------------------------------------
  // power control register
  // ----------------------------------------
  // go bits only take effect when armed by the previous write; the two-step
  // sequence guards against a stray write stopping the part
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pctl_r <= pwr_save_pkg::PCTL_RESET; // RULE14
    end else if (pctl_we_i && mode_r == pwr_save_pkg::MODE_RUN) begin
      pctl_r[pwr_save_pkg::SLOW_BIT] <= pctl_wdata_i[pwr_save_pkg::SLOW_BIT]; // RULE12
      pctl_r[pwr_save_pkg::IDLE_ARM_BIT] <= pctl_wdata_i[pwr_save_pkg::IDLE_ARM_BIT];
      pctl_r[pwr_save_pkg::PDOWN_ARM_BIT] <= pctl_wdata_i[pwr_save_pkg::PDOWN_ARM_BIT];
      pctl_r[pwr_save_pkg::IDLE_GO_BIT] <= pctl_wdata_i[pwr_save_pkg::IDLE_GO_BIT]
                                          && pctl_r[pwr_save_pkg::IDLE_ARM_BIT]; // RULE5
      pctl_r[pwr_save_pkg::PDOWN_GO_BIT] <= pctl_wdata_i[pwr_save_pkg::PDOWN_GO_BIT]
                                           && pctl_r[pwr_save_pkg::PDOWN_ARM_BIT]; // RULE8
    end else if (mode_r == pwr_save_pkg::MODE_IDLE && (periph_irq_i || pin_wake)) begin
      pctl_r[pwr_save_pkg::IDLE_GO_BIT] <= 1'b0;
      pctl_r[pwr_save_pkg::IDLE_ARM_BIT] <= 1'b0;
    end else if (mode_r == pwr_save_pkg::MODE_WAKE && wake_cnt_r == WAKE_LAST) begin
      pctl_r[pwr_save_pkg::PDOWN_GO_BIT] <= 1'b0;
      pctl_r[pwr_save_pkg::PDOWN_ARM_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= pwr_save_pkg::MODE_RUN; // RULE14
    end else begin
      case (mode_r)
        pwr_save_pkg::MODE_RUN: begin
          if (pctl_r[pwr_save_pkg::PDOWN_GO_BIT]) begin
            mode_r <= pwr_save_pkg::MODE_PDOWN; // RULE8
          end else if (pctl_r[pwr_save_pkg::IDLE_GO_BIT]) begin
            mode_r <= pwr_save_pkg::MODE_IDLE; // RULE5
          end
        end
        pwr_save_pkg::MODE_IDLE: begin
          if (periph_irq_i) begin
            mode_r <= pwr_save_pkg::MODE_RUN; // RULE4
          end
        end
        pwr_save_pkg::MODE_PDOWN: begin
          if (pin_wake) begin
            mode_r <= pwr_save_pkg::MODE_WAKE; // RULE9
          end
        end
        pwr_save_pkg::MODE_WAKE: begin
          if (wake_cnt_r == WAKE_LAST) begin
            mode_r <= pwr_save_pkg::MODE_RUN; // RULE10
          end
        end
        default: mode_r <= pwr_save_pkg::MODE_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // wake-up settle counter and interrupt
  // ----------------------------------------
  // the oscillator restarts at wake entry; counting stands in for its settling
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_cnt_r <= 32'h0000_0000;
    end else if (mode_r == pwr_save_pkg::MODE_WAKE) begin
      wake_cnt_r <= wake_cnt_r + 32'h0000_0001; // RULE10
    end else begin
      wake_cnt_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_irq_r <= 1'b0;
    end else begin
      wake_irq_r <= (mode_r == pwr_save_pkg::MODE_WAKE) && (wake_cnt_r == WAKE_LAST); // RULE10
    end
  end

  // ----------------------------------------
  // slow-down divider
  // ----------------------------------------
  clk_div_en u_div (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .run_i    (pctl_r[pwr_save_pkg::SLOW_BIT]),
    .tick_o   (div_tick)
  );

  // ----------------------------------------
  // clock gating outputs
  // ----------------------------------------
  // enables rather than gated clocks; a full-rate enable is constant high
  logic base_en;
  assign base_en      = pctl_r[pwr_save_pkg::SLOW_BIT] ? div_tick : 1'b1; // RULE11
  assign per_clk_en_o = (mode_r == pwr_save_pkg::MODE_RUN ||
                         mode_r == pwr_save_pkg::MODE_IDLE) && base_en; // RULE2 RULE13
  assign cpu_clk_en_o = (mode_r == pwr_save_pkg::MODE_RUN) && base_en; // RULE1 RULE3
  assign osc_en_o     = (mode_r != pwr_save_pkg::MODE_PDOWN); // RULE6
  assign hold_state_o = (mode_r != pwr_save_pkg::MODE_RUN); // RULE7
  assign idle_o       = (mode_r == pwr_save_pkg::MODE_IDLE);
  assign pdown_o      = (mode_r == pwr_save_pkg::MODE_PDOWN) ||
                        (mode_r == pwr_save_pkg::MODE_WAKE);
  assign wake_irq_o   = wake_irq_r;
  assign pctl_rdata_o = pctl_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_idle_armed;
    pctl_we_i && pctl_wdata_i[pwr_save_pkg::IDLE_ARM_BIT] && mode_r == pwr_save_pkg::MODE_RUN;
  endsequence
  sequence s_idle_go;
    pctl_we_i && pctl_wdata_i[pwr_save_pkg::IDLE_GO_BIT] &&
    !pctl_wdata_i[pwr_save_pkg::PDOWN_GO_BIT];
  endsequence

  property p_idle_entry;
    @(posedge mclk_i) disable iff (!resetn_i)
    s_idle_armed ##1 s_idle_go |-> ##2 idle_o;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered"); // RULE5

  property p_go_needs_arm;
    @(posedge mclk_i) disable iff (!resetn_i)
    (pctl_we_i && mode_r == pwr_save_pkg::MODE_RUN &&
     !pctl_r[pwr_save_pkg::PDOWN_ARM_BIT]) |=> !pctl_r[pwr_save_pkg::PDOWN_GO_BIT];
  endproperty
  a_go_needs_arm: assert property (p_go_needs_arm) else $error("unarmed power-down"); // RULE8

  property p_idle_cpu_off;
    @(posedge mclk_i) disable iff (!resetn_i)
    idle_o |-> !cpu_clk_en_o && osc_en_o;
  endproperty
  a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("cpu clocked in idle"); // RULE1

  property p_idle_per_on;
    @(posedge mclk_i) disable iff (!resetn_i)
    (idle_o && !pctl_r[pwr_save_pkg::SLOW_BIT]) |-> per_clk_en_o;
  endproperty
  a_idle_per_on: assert property (p_idle_per_on) else $error("peripherals stopped"); // RULE2

  property p_idle_exit;
    @(posedge mclk_i) disable iff (!resetn_i)
    (idle_o && periph_irq_i) |=> !idle_o && !hold_state_o;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left"); // RULE4

  property p_pdown_off;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == pwr_save_pkg::MODE_PDOWN) |-> !osc_en_o && !per_clk_en_o && hold_state_o;
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("activity in power-down"); // RULE6

  property p_pin_wake;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == pwr_save_pkg::MODE_PDOWN && pin_wake) |=> osc_en_o && !cpu_clk_en_o;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake failed"); // RULE9

  property p_wake_irq;
    @(posedge mclk_i) disable iff (!resetn_i)
    $rose(wake_irq_o) |-> $past(mode_r) == pwr_save_pkg::MODE_WAKE && !pdown_o;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("bad wake interrupt"); // RULE10

  // a clear of the slow bit may land right after a tick; full rate is then legal at once
  property p_slow_rate;
    @(posedge mclk_i) disable iff (!resetn_i)
    (per_clk_en_o && pctl_r[pwr_save_pkg::SLOW_BIT] &&
     $stable(pctl_r[pwr_save_pkg::SLOW_BIT])) |=>
    (!per_clk_en_o || !pctl_r[pwr_save_pkg::SLOW_BIT]) [*8];
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow rate wrong"); // RULE11

  // back-to-back power-down entry, no other entry pending
  sequence s_pdown_armed;
    pctl_we_i && pctl_wdata_i[pwr_save_pkg::PDOWN_ARM_BIT] &&
    !pctl_wdata_i[pwr_save_pkg::IDLE_GO_BIT] && mode_r == pwr_save_pkg::MODE_RUN &&
    !pctl_r[pwr_save_pkg::IDLE_GO_BIT] && !pctl_r[pwr_save_pkg::PDOWN_GO_BIT];
  endsequence
  sequence s_pdown_go;
    pctl_we_i && pctl_wdata_i[pwr_save_pkg::PDOWN_GO_BIT];
  endsequence

  property p_pdown_entry;
    @(posedge mclk_i) disable iff (!resetn_i)
    s_pdown_armed ##1 s_pdown_go |-> ##2 pdown_o;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry) else $error("power-down not entered"); // RULE8

  property p_pdown_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == pwr_save_pkg::MODE_PDOWN) |=> $stable(pctl_r);
  endproperty
  a_pdown_hold: assert property (p_pdown_hold) else $error("register lost in power-down"); // RULE7

  property p_idle_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
    (idle_o && !periph_irq_i && !pin_wake) |=> $stable(pctl_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("register changed in idle"); // RULE3

  // no cpu clock and still in power-down for the first 8 cycles after a pin wake
  property p_wake_settle;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == pwr_save_pkg::MODE_PDOWN && pin_wake) |=> (pdown_o && !cpu_clk_en_o) [*8];
  endproperty
  a_wake_settle: assert property (p_wake_settle) else $error("wake settle too short"); // RULE10

  property p_wake_pulse;
    @(posedge mclk_i) disable iff (!resetn_i)
    wake_irq_o |=> !wake_irq_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake interrupt too long"); // RULE10

  property p_slow_set;
    @(posedge mclk_i) disable iff (!resetn_i)
    (pctl_we_i && mode_r == pwr_save_pkg::MODE_RUN && pctl_wdata_i[pwr_save_pkg::SLOW_BIT])
    |=> pctl_r[pwr_save_pkg::SLOW_BIT];
  endproperty
  a_slow_set: assert property (p_slow_set) else $error("slow bit not set"); // RULE12

  property p_slow_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
    (pctl_we_i && mode_r == pwr_save_pkg::MODE_RUN && !pctl_wdata_i[pwr_save_pkg::SLOW_BIT])
    |=> !pctl_r[pwr_save_pkg::SLOW_BIT];
  endproperty
  a_slow_clear: assert property (p_slow_clear) else $error("slow bit not cleared"); // RULE12

  // idle peripherals follow the divided rate exactly
  property p_slow_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
    (idle_o && pctl_r[pwr_save_pkg::SLOW_BIT]) |-> !cpu_clk_en_o && (per_clk_en_o == div_tick);
  endproperty
  a_slow_idle: assert property (p_slow_idle) else $error("idle slow rate wrong"); // RULE13

  property p_full_rate;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mode_r == pwr_save_pkg::MODE_RUN && !pctl_r[pwr_save_pkg::SLOW_BIT]) |->
    cpu_clk_en_o && per_clk_en_o && osc_en_o && !hold_state_o;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("run not at full rate"); // RULE14

endmodule

// *** sim/tb_power_saving_mode_control.sv ***
`timescale 1ns/10ps
module tb_power_saving_mode_control;
  localparam int WAKE_SIM = 16;  // short settle keeps the run brief

  logic       mclk_i;
  logic       resetn_i;
  logic       pctl_we_i;
  logic [7:0] pctl_wdata_i;
  logic [7:0] pctl_rdata_o;
  logic       periph_irq_i;
  logic       ext_external_interrupt_zero_pin_i;
  logic       can_rx_i;
  logic       osc_en_o;
  logic       cpu_clk_en_o;
  logic       per_clk_en_o;
  logic       hold_state_o;
  logic       wake_irq_o;
  logic       idle_o;
  logic       pdown_o;
  logic [7:0] st;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  int         c_cpu;
  int         c_per;
  int         n;

  // ----------------------------------------
  // design and packed status view
  // ----------------------------------------
  power_saving_mode_control #(.WAKE_CYC(WAKE_SIM)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .pctl_we_i(pctl_we_i),
    .pctl_wdata_i(pctl_wdata_i), .pctl_rdata_o(pctl_rdata_o),
    .periph_irq_i(periph_irq_i), .ext_external_interrupt_zero_pin_i(ext_external_interrupt_zero_pin_i), .can_rx_i(can_rx_i),
    .osc_en_o(osc_en_o), .cpu_clk_en_o(cpu_clk_en_o), .per_clk_en_o(per_clk_en_o),
    .hold_state_o(hold_state_o), .wake_irq_o(wake_irq_o), .idle_o(idle_o),
    .pdown_o(pdown_o)
  );
  // order: osc, cpu, per, hold, wake, idle, pdown
  assign st = {1'b0, osc_en_o, cpu_clk_en_o, per_clk_en_o, hold_state_o, wake_irq_o, idle_o,
               pdown_o};

  // 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs always move 1 ns after the edge
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic tmo;
    n_mismatch++;
    $display("ERROR %0t wait limit reached", $time);
    complete_run;
  endtask

  task automatic wr(input logic [7:0] v);
    step(1);
    pctl_we_i    = 1'b1;
    pctl_wdata_i = v;
    step(1);
    pctl_we_i    = 1'b0;
  endtask

  // back-to-back pair: strobe held high across both edges
  task automatic wr2(input logic [7:0] a, input logic [7:0] b);
    step(1);
    pctl_we_i    = 1'b1;
    pctl_wdata_i = a;
    step(1);
    pctl_wdata_i = b;
    step(1);
    pctl_we_i    = 1'b0;
  endtask

  task automatic do_reset;
    resetn_i = 1'b0;
    step(2);
    resetn_i = 1'b1;
  endtask

  // any 64 consecutive cycles hold exactly two ticks of a /32 train
  task automatic count_en(input int k);
    c_cpu = 0;
    c_per = 0;
    repeat (k) begin
      step(1);
      c_cpu += (cpu_clk_en_o === 1'b1);
      c_per += (per_clk_en_o === 1'b1);
    end
  endtask

  task automatic irq_pulse;
    periph_irq_i = 1'b1;
    step(1);
    periph_irq_i = 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle;
    wr(8'h01);
    chk(pctl_rdata_o, 8'h01);
    wr(8'h21);
    chk(pctl_rdata_o, 8'h21);
    step(2);
    chk(st, 8'h5a);
    wr(8'h00);
    chk(pctl_rdata_o, 8'h21);
    irq_pulse();
    chk(st, 8'h70);
    chk(pctl_rdata_o, 8'h00);
  endtask

  // go bit alone must be dropped
  task automatic t_refuse;
    for (int i = 0; i < 2; i++) begin
      wr(i == 0 ? 8'h20 : 8'h40);
      step(2);
      chk(pctl_rdata_o, 8'h00);
      chk(st, 8'h70);
    end
  endtask

  task automatic t_pdown(input bit use_can);
    wr2(8'h02, 8'h42);
    step(2);
    chk(st, 8'h09);
    irq_pulse();
    step(2);
    chk(st, 8'h09);
    if (use_can) can_rx_i = 1'b0;
    else ext_external_interrupt_zero_pin_i = 1'b0;
    step(4);
    can_rx_i   = 1'b1;
    ext_external_interrupt_zero_pin_i = 1'b1;
    n = 0;
    while (osc_en_o !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    if (n == 50) tmo();
    n = 0;
    while (wake_irq_o !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    if (n == 200) tmo();
    chk(8'(n >= WAKE_SIM - 1 && n <= WAKE_SIM + 1), 8'h01);
    step(1);
    chk(st, 8'h70);
    chk(pctl_rdata_o, 8'h00);
  endtask

  task automatic t_slow;
    wr(8'h10);
    chk(pctl_rdata_o, 8'h10);
    step(16);
    count_en(64);
    chk(8'(c_cpu), 8'h02);
    chk(8'(c_per), 8'h02);
    wr2(8'h11, 8'h31);
    step(2);
    count_en(64);
    chk(8'(c_cpu), 8'h00);
    chk(8'(c_per), 8'h02);
    irq_pulse();
    chk(pctl_rdata_o, 8'h10);
    wr(8'h10 & 8'hef);
    chk(pctl_rdata_o, 8'h00);
    count_en(64);
    chk(8'(c_cpu), 8'h40);
    wr(8'h10);
    do_reset();
    chk(pctl_rdata_o, 8'h00);
    chk(st, 8'h70);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn_i     = 1'b0;
    pctl_we_i    = 1'b0;
    pctl_wdata_i = 8'h00;
    periph_irq_i = 1'b0;
    ext_external_interrupt_zero_pin_i   = 1'b1;
    can_rx_i     = 1'b1;
    do_reset();
    chk(pctl_rdata_o, 8'h00);
    chk(st, 8'h70);
    t_idle();
    t_refuse();
    t_pdown(1'b0);
    t_pdown(1'b1);
    t_slow();
    complete_run();
  end
endmodule
